// *** rtl/wsio_pkg.sv ***
// constants, codes and helpers for the weighing setpoint i/o block
package wsio_pkg;
  // geometry
  localparam int NUM_IN = 4;
  localparam int NUM_OUT = 5;
  localparam int NUM_SP = 5;
  localparam int WW = 32;
  localparam int AW = 8;
  // register byte addresses
  localparam logic [7:0] ADDR_IN_FUNC = 8'h00;
  localparam logic [7:0] ADDR_OUT_FUNC = 8'h04;
  localparam logic [7:0] ADDR_APP_MASK = 8'h08;
  localparam logic [7:0] ADDR_ZERO_LIM = 8'h0c;
  localparam logic [7:0] ADDR_SP_BASE = 8'h10;
  localparam logic [7:0] ADDR_SP_LAST = 8'h20;
  localparam logic [7:0] ADDR_REM_SET = 8'h24;
  localparam logic [7:0] ADDR_REM_CLR = 8'h28;
  localparam logic [7:0] ADDR_ENTRY_CTRL = 8'h2c;
  localparam logic [7:0] ADDR_ENTRY_DATA = 8'h30;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  // field layout
  localparam int IN_FW = 4;
  localparam int OUT_FW = 5;
  localparam int APP_IN_LSB = 8;
  localparam int ST_DIN_LSB = 8;
  localparam int ST_ENTRY_ACT = 16;
  localparam int ST_ENTRY_IDX_LSB = 17;
  localparam int ENTRY_START_BIT = 0;
  localparam int ENTRY_ABORT_BIT = 1;
  localparam logic [2:0] SP_LAST_IDX = 3'h4;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // reset values
  localparam logic [31:0] RST_WORD = 32'h0;
  // digital input function codes
  localparam logic [3:0] IN_NONE = 4'h0;
  localparam logic [3:0] IN_ZERO = 4'h1;
  localparam logic [3:0] IN_TARE = 4'h2;
  localparam logic [3:0] IN_CLEAR = 4'h3;
  localparam logic [3:0] IN_PRINT = 4'h4;
  localparam logic [3:0] IN_KEYLOCK = 4'h5;
  localparam logic [3:0] IN_PEAK = 4'h6;
  localparam logic [3:0] IN_HOLD = 4'h7;
  // serial command characters
  localparam logic [7:0] CH_PRINT = 8'h50;
  localparam logic [7:0] CH_ZERO = 8'h5a;
  localparam logic [7:0] CH_TARE = 8'h54;
  localparam logic [7:0] CH_CLEAR = 8'h43;
  // digital output function codes
  localparam logic [4:0] OM_OFF = 5'h00;
  localparam logic [4:0] OM_ABS_IND = 5'h01;
  localparam logic [4:0] OM_IND = 5'h02;
  localparam logic [4:0] OM_WIN_HI_IND = 5'h03;
  localparam logic [4:0] OM_WIN_LO_IND = 5'h04;
  localparam logic [4:0] OM_ABS_NET = 5'h05;
  localparam logic [4:0] OM_NET = 5'h06;
  localparam logic [4:0] OM_WIN_HI_NET = 5'h07;
  localparam logic [4:0] OM_WIN_LO_NET = 5'h08;
  localparam logic [4:0] OM_GROSS = 5'h09;
  localparam logic [4:0] OM_STAGED1 = 5'h0a;
  localparam logic [4:0] OM_STAGED2 = 5'h0b;
  localparam logic [4:0] OM_ZERO_IND = 5'h0c;
  localparam logic [4:0] OM_ZERO_GROSS = 5'h0d;
  localparam logic [4:0] OM_STABLE = 5'h0e;
  localparam logic [4:0] OM_RUN = 5'h0f;
  localparam logic [4:0] OM_NET_SHOWN = 5'h10;
  localparam logic [4:0] OM_ERROR = 5'h11;
  localparam logic [4:0] OM_REMOTE = 5'h12;

  // sign-extended copy so magnitudes never overflow
  function automatic logic signed [32:0] wsio_ext(logic signed [31:0] v);
    return {v[31], v};
  endfunction

  // magnitude, sign ignored
  function automatic logic signed [32:0] wsio_mag(logic signed [31:0] v);
    return v[31] ? -wsio_ext(v) : wsio_ext(v);
  endfunction
endpackage

// *** rtl/wsio_out_cmp.sv ***
// one digital output's function evaluator (combinational)
`timescale 1ns/1ps
`default_nettype none
module wsio_out_cmp
(
  // selection
  input wire logic [4:0] mode,
  input wire logic is_last,
  // weights and limits
  input wire logic signed [31:0] ind,
  input wire logic signed [31:0] net,
  input wire logic signed [31:0] gross,
  input wire logic signed [31:0] sp_lo,
  input wire logic signed [31:0] sp_hi,
  input wire logic signed [31:0] zero_lim,
  // status sources
  input wire logic stable,
  input wire logic net_shown,
  input wire logic err_shown,
  input wire logic run_ok,
  input wire logic remote_bit,
  // result
  output var logic hit,
  output var logic weight_mode
);
  logic signed [32:0] lo;
  logic signed [32:0] hi;
  logic signed [32:0] wi;
  logic signed [32:0] wn;
  logic signed [32:0] wg;
  logic in_win_i;
  logic in_win_n;

  // shared window compares, bounds inclusive
  always_comb
  begin
    lo = wsio_pkg::wsio_ext(sp_lo);
    hi = wsio_pkg::wsio_ext(sp_hi);
    wi = wsio_pkg::wsio_ext(ind);
    wn = wsio_pkg::wsio_ext(net);
    wg = wsio_pkg::wsio_ext(gross);
    in_win_i = (wi >= lo) && (wi <= hi);
    in_win_n = (wn >= lo) && (wn <= hi);
  end

  // function select; single setpoint compares are weight >= setpoint
  always_comb
  begin
    weight_mode = 1'b1;
    case (mode)
      wsio_pkg::OM_ABS_IND: hit = wsio_pkg::wsio_mag(ind) >= lo;
      wsio_pkg::OM_IND: hit = wi >= lo;
      wsio_pkg::OM_WIN_HI_IND: hit = in_win_i;
      wsio_pkg::OM_WIN_LO_IND: hit = !in_win_i;
      wsio_pkg::OM_ABS_NET: hit = wsio_pkg::wsio_mag(net) >= lo;
      wsio_pkg::OM_NET: hit = wn >= lo;
      wsio_pkg::OM_WIN_HI_NET: hit = in_win_n;
      wsio_pkg::OM_WIN_LO_NET: hit = !in_win_n;
      wsio_pkg::OM_GROSS: hit = wg >= lo;
      // cumulative stages; relies on rising setpoints
      wsio_pkg::OM_STAGED1: hit = wi >= lo;
      // only the current stage; last stage stays on
      wsio_pkg::OM_STAGED2: hit = (wi >= lo) && (is_last || wi < hi);
      wsio_pkg::OM_ZERO_IND:
        hit = wsio_pkg::wsio_mag(ind) <= wsio_pkg::wsio_ext(zero_lim);
      wsio_pkg::OM_ZERO_GROSS:
        hit = wsio_pkg::wsio_mag(gross) <= wsio_pkg::wsio_ext(zero_lim);
      default:
      begin
        weight_mode = 1'b0;
        case (mode)
          wsio_pkg::OM_STABLE: hit = stable;
          wsio_pkg::OM_RUN: hit = run_ok;
          wsio_pkg::OM_NET_SHOWN: hit = net_shown;
          wsio_pkg::OM_ERROR: hit = err_shown;
          wsio_pkg::OM_REMOTE: hit = remote_bit;
          default: hit = 1'b0;
        endcase
      end
    endcase
  end
endmodule
`default_nettype wire

// *** rtl/wsio_top.sv ***
// digital input/output and setpoint logic of the weighing terminal
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module wsio_top
(
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // measurement core
  input wire logic sample_valid,
  input wire logic signed [31:0] ind_weight,
  input wire logic signed [31:0] net_weight,
  input wire logic signed [31:0] gross_weight,
  input wire logic stable,
  input wire logic net_shown,
  input wire logic err_shown,
  input wire logic power_on_busy,
  input wire logic setup_active,
  // serial command characters
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // application program
  input wire logic [4:0] app_dout,
  output logic [3:0] app_din,
  // digital pins
  input wire logic [3:0] din,
  output logic [4:0] dout,
  // key actions
  output logic key_zero,
  output logic key_tare,
  output logic key_clear,
  output logic key_print,
  output logic key_lock,
  output logic peak_show,
  output logic hold_display
);
  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0][3:0] in_func;
    logic [4:0][4:0] out_func;
    logic [4:0] app_out_mask;
    logic [3:0] app_in_mask;
    logic [31:0] zero_lim;
    logic [4:0][31:0] sp;
    logic [4:0] remote;
    logic entry_active;
    logic [2:0] entry_idx;
    logic [3:0] din_prev;
    logic [3:0] keys;
    logic key_lock;
    logic peak;
    logic hold;
    logic [4:0] dout;
    logic [3:0] app_din;
  } wsio_state_t;

  wsio_state_t st_reg;
  wsio_state_t st_next;
  logic [4:0] hit;
  logic [4:0] wmode;
  logic run_ok;
  // base for mask, remote and entry writes, so unstrobed lanes land as zero
  localparam logic [31:0] RST_W = wsio_pkg::RST_WORD;

  // byte-lane merge for partial writes
  function automatic logic [31:0] wsio_merge(logic [31:0] old,
    logic [31:0] nw, logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction

  // address decode shared by read and write paths
  function automatic logic wsio_mapped(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= wsio_pkg::ADDR_STATUS);
  endfunction

  // setpoint index of a setpoint address
  function automatic logic [2:0] wsio_sp_idx(logic [7:0] a);
    logic [7:0] d;
    d = a - wsio_pkg::ADDR_SP_BASE;
    return d[4:2];
  endfunction

  // does input code c on an unowned pin select function f
  function automatic logic wsio_in_is(logic [3:0] c, logic [3:0] f);
    return c == f;
  endfunction

  // output low during power-on and any setup mode
  assign run_ok = !power_on_busy && !setup_active;

  // one evaluator per output; windows and OM_STAGED2 use the next setpoint, the last output wrapping to setpoint 0
  generate
    for (genvar i = 0; i < wsio_pkg::NUM_OUT; i++)
    begin : g_out
      wsio_out_cmp u_cmp (
        .mode(st_reg.out_func[i]),
        .is_last(i == wsio_pkg::NUM_OUT - 1),
        .ind(ind_weight),
        .net(net_weight),
        .gross(gross_weight),
        .sp_lo(st_reg.sp[i]),
        .sp_hi(st_reg.sp[(i + 1) % wsio_pkg::NUM_SP]),
        .zero_lim(st_reg.zero_lim),
        .stable(stable),
        .net_shown(net_shown),
        .err_shown(err_shown),
        .run_ok(run_ok),
        .remote_bit(st_reg.remote[i]),
        .hit(hit[i]),
        .weight_mode(wmode[i])
      );
    end
  endgenerate

  // next-state logic for bus, configuration, inputs and outputs
  always_comb
  begin
    logic [3:0] rise;
    logic [7:0] a;
    logic [31:0] wv;
    st_next = st_reg;
    rise = din & ~st_reg.din_prev;
    a = st_reg.aw_addr;
    wv = wsio_merge(RST_W, st_reg.w_data, st_reg.w_strb);
    // write channel capture, address and data in either order
    if (s_axi_awvalid && st_reg.awready)
    begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_reg.wready)
    begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    // commit once both halves are held
    if (st_reg.aw_full && st_reg.w_full && !st_reg.bvalid)
    begin
      st_next.aw_full = 1'b0;
      st_next.w_full = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wsio_mapped(a) ? wsio_pkg::RESP_OKAY
                                     : wsio_pkg::RESP_SLVERR;
      if (a == wsio_pkg::ADDR_IN_FUNC)
        st_next.in_func = 16'(wsio_merge({16'h0, st_reg.in_func},
                                         st_reg.w_data, st_reg.w_strb));
      else if (a == wsio_pkg::ADDR_OUT_FUNC)
        st_next.out_func = 25'(wsio_merge({7'h0, st_reg.out_func},
                                          st_reg.w_data, st_reg.w_strb));
      else if (a == wsio_pkg::ADDR_APP_MASK)
      begin
        st_next.app_out_mask = wv[4:0];
        st_next.app_in_mask = wv[wsio_pkg::APP_IN_LSB +: 4];
      end
      else if (a == wsio_pkg::ADDR_ZERO_LIM)
        st_next.zero_lim = wsio_merge(st_reg.zero_lim, st_reg.w_data,
                                      st_reg.w_strb);
      else if (a >= wsio_pkg::ADDR_SP_BASE && a <= wsio_pkg::ADDR_SP_LAST)
        st_next.sp[wsio_sp_idx(a)] = wsio_merge(st_reg.sp[wsio_sp_idx(a)],
                                                st_reg.w_data, st_reg.w_strb);
      else if (a == wsio_pkg::ADDR_REM_SET)
        st_next.remote = st_reg.remote | wv[4:0];
      else if (a == wsio_pkg::ADDR_REM_CLR)
        st_next.remote = st_reg.remote & ~wv[4:0];
      else if (a == wsio_pkg::ADDR_ENTRY_CTRL)
      begin
        if (wv[wsio_pkg::ENTRY_START_BIT])
        begin
          st_next.entry_active = 1'b1;
          st_next.entry_idx = 3'h0;
        end
        if (wv[wsio_pkg::ENTRY_ABORT_BIT])
          st_next.entry_active = 1'b0;
      end
      else if (a == wsio_pkg::ADDR_ENTRY_DATA && st_reg.entry_active)
      begin
        // accept value, step to next setpoint, leave after the fifth
        st_next.sp[st_reg.entry_idx] = wv;
        if (st_reg.entry_idx == wsio_pkg::SP_LAST_IDX)
        begin
          st_next.entry_active = 1'b0;
          st_next.entry_idx = 3'h0;
        end
        else
          st_next.entry_idx = st_reg.entry_idx + 3'h1;
      end
    end
    // read channel, one outstanding read
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (s_axi_arvalid && st_reg.arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = wsio_mapped(s_axi_araddr) ? wsio_pkg::RESP_OKAY
                                                : wsio_pkg::RESP_SLVERR;
      st_next.rdata = 32'h0;
      case (s_axi_araddr)
        wsio_pkg::ADDR_IN_FUNC: st_next.rdata = {16'h0, st_reg.in_func};
        wsio_pkg::ADDR_OUT_FUNC: st_next.rdata = {7'h0, st_reg.out_func};
        wsio_pkg::ADDR_APP_MASK:
          st_next.rdata = {20'h0, st_reg.app_in_mask, 3'h0,
                           st_reg.app_out_mask};
        wsio_pkg::ADDR_ZERO_LIM: st_next.rdata = st_reg.zero_lim;
        wsio_pkg::ADDR_REM_SET, wsio_pkg::ADDR_REM_CLR:
          st_next.rdata = {27'h0, st_reg.remote};
        wsio_pkg::ADDR_ENTRY_CTRL:
          st_next.rdata = {28'h0, st_reg.entry_idx, st_reg.entry_active};
        wsio_pkg::ADDR_STATUS:
          st_next.rdata = {12'h0, st_reg.entry_idx, st_reg.entry_active,
                           4'h0, din, 3'h0, st_reg.dout};
        default:
          if (s_axi_araddr >= wsio_pkg::ADDR_SP_BASE &&
              s_axi_araddr <= wsio_pkg::ADDR_SP_LAST)
            st_next.rdata = st_reg.sp[wsio_sp_idx(s_axi_araddr)];
      endcase
    end
    st_next.awready = !st_next.aw_full && !st_next.bvalid;
    st_next.wready = !st_next.w_full && !st_next.bvalid;
    st_next.arready = !st_next.rvalid;
    // serial characters act as key presses
    st_next.keys[0] = rx_valid && rx_data == wsio_pkg::CH_ZERO;
    st_next.keys[1] = rx_valid && rx_data == wsio_pkg::CH_TARE;
    st_next.keys[2] = rx_valid && rx_data == wsio_pkg::CH_CLEAR;
    st_next.keys[3] = rx_valid && rx_data == wsio_pkg::CH_PRINT;
    st_next.key_lock = 1'b0;
    st_next.peak = 1'b0;
    st_next.hold = 1'b0;
    st_next.din_prev = din;
    // digital inputs: key functions on rising edge, others as levels
    for (int i = 0; i < wsio_pkg::NUM_IN; i++)
    begin
      if (!st_reg.app_in_mask[i])
      begin
        st_next.keys[0] |= rise[i] &&
          wsio_in_is(st_reg.in_func[i], wsio_pkg::IN_ZERO);
        st_next.keys[1] |= rise[i] &&
          wsio_in_is(st_reg.in_func[i], wsio_pkg::IN_TARE);
        st_next.keys[2] |= rise[i] &&
          wsio_in_is(st_reg.in_func[i], wsio_pkg::IN_CLEAR);
        st_next.keys[3] |= rise[i] &&
          wsio_in_is(st_reg.in_func[i], wsio_pkg::IN_PRINT);
        st_next.key_lock |= din[i] &&
          wsio_in_is(st_reg.in_func[i], wsio_pkg::IN_KEYLOCK);
        st_next.peak |= din[i] &&
          wsio_in_is(st_reg.in_func[i], wsio_pkg::IN_PEAK);
        st_next.hold |= din[i] &&
          wsio_in_is(st_reg.in_func[i], wsio_pkg::IN_HOLD);
      end
    end
    st_next.app_din = din & st_reg.app_in_mask;
    // outputs: weight compares only on a new sample, others every cycle
    for (int i = 0; i < wsio_pkg::NUM_OUT; i++)
    begin
      if (st_reg.app_out_mask[i])
        st_next.dout[i] = app_dout[i];
      else if (sample_valid || !wmode[i])
        st_next.dout[i] = hit[i];
    end
  end

  // single state register; ce low freezes everything except the synchronous reset, which loads zero regardless of ce
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  // every output straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign dout = st_reg.dout;
  assign app_din = st_reg.app_din;
  assign key_zero = st_reg.keys[0];
  assign key_tare = st_reg.keys[1];
  assign key_clear = st_reg.keys[2];
  assign key_print = st_reg.keys[3];
  assign key_lock = st_reg.key_lock;
  assign peak_show = st_reg.peak;
  assign hold_display = st_reg.hold;

  // checks on output 0, the key paths and the end of setpoint entry
  serial_tare_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && rx_valid && rx_data == wsio_pkg::CH_TARE) |=> key_tare)
    else $error("serial tare char gave no tare pulse");
  input_tare_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !st_reg.app_in_mask[0] && din[0] && !st_reg.din_prev[0] &&
     st_reg.in_func[0] == wsio_pkg::IN_TARE) |=> key_tare)
    else $error("input tare edge gave no tare pulse");
  peak_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !st_reg.app_in_mask[1] && din[1] &&
     st_reg.in_func[1] == wsio_pkg::IN_PEAK) |=> peak_show)
    else $error("peak input not shown");
  run_setup_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !st_reg.app_out_mask[0] && setup_active &&
     st_reg.out_func[0] == wsio_pkg::OM_RUN) |=> !dout[0])
    else $error("run output high during setup");
  stable_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !st_reg.app_out_mask[0] &&
     st_reg.out_func[0] == wsio_pkg::OM_STABLE) |=> dout[0] == $past(stable))
    else $error("stable output does not follow stable flag");
  remote_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !st_reg.app_out_mask[0] &&
     st_reg.out_func[0] == wsio_pkg::OM_REMOTE)
    |=> dout[0] == $past(st_reg.remote[0]))
    else $error("remote output does not follow command");
  entry_exit_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && st_reg.entry_active && st_reg.aw_full && st_reg.w_full &&
     !st_reg.bvalid && st_reg.aw_addr == wsio_pkg::ADDR_ENTRY_DATA &&
     st_reg.entry_idx == wsio_pkg::SP_LAST_IDX) |=> !st_reg.entry_active)
    else $error("entry did not end after fifth setpoint");
  ind_ge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && sample_valid && !st_reg.app_out_mask[0] &&
     st_reg.out_func[0] == wsio_pkg::OM_IND)
    |=> dout[0] == ($past(ind_weight) >= $past($signed(st_reg.sp[0]))))
    else $error("indicated setpoint compare wrong");
  win_hi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && sample_valid && !st_reg.app_out_mask[0] &&
     st_reg.out_func[0] == wsio_pkg::OM_WIN_HI_IND &&
     ind_weight >= $signed(st_reg.sp[0]) &&
     ind_weight <= $signed(st_reg.sp[1])) |=> dout[0])
    else $error("window output low inside window");
endmodule
`default_nettype wire

// *** verif/wsio_core_model.sv ***
// behavioural measurement core feeding weights and status levels
`timescale 1ns/1ps
`default_nettype none
module wsio_core_model
(
  // clock and bench settings
  input wire logic aclk,
  input wire logic signed [31:0] w_set,
  input wire logic [4:0] st_set,
  // weights and status to the block
  output logic sample_valid = 1'b0,
  output logic signed [31:0] ind_weight = 32'sh0,
  output logic signed [31:0] net_weight = 32'sh0,
  output logic signed [31:0] gross_weight = 32'sh0,
  output logic [4:0] st = 5'h0
);
  logic [1:0] cnt = 2'h0;
  // a fresh sample every fourth cycle; weights hold between samples
  always_ff @(posedge aclk)
  begin
    cnt <= cnt + 2'h1;
    sample_valid <= (cnt == 2'h0);
    if (cnt == 2'h0)
    begin
      ind_weight <= w_set;
      net_weight <= w_set - 32'sd100; // a tare of 100 stays applied
      gross_weight <= w_set;
    end
    st <= st_set;
  end
endmodule
`default_nettype wire

// *** verif/weight_setpoint_io_logic_test.sv ***
// self-checking bench for the weighing setpoint i/o block
`timescale 1ns/1ps
`default_nettype none
module weight_setpoint_io_logic_test;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, rx_data = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, sample_valid, key_lock, peak_show, hold_display;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic signed [31:0] ind_weight, net_weight, gross_weight;
  logic signed [31:0] w_set = 32'sh0;
  logic [4:0] st, st_set = 5'h0, dout;
  logic [3:0] din = 4'h0, app_din, keys;
  int failures = 0, cmp_count = 0, cyc = 0;
  wsio_core_model core (.aclk, .w_set, .st_set, .sample_valid,
    .ind_weight, .net_weight, .gross_weight, .st);
  wsio_top DUT (.aclk, .aresetn, .ce(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample_valid, .ind_weight,
    .net_weight, .gross_weight, .stable(st[0]), .net_shown(st[1]),
    .err_shown(st[2]), .power_on_busy(st[3]), .setup_active(st[4]),
    .rx_valid, .rx_data, .app_dout(5'h0), .app_din, .din, .dout,
    .key_zero(keys[0]), .key_tare(keys[1]), .key_clear(keys[2]),
    .key_print(keys[3]), .key_lock, .peak_show, .hold_display);
  // 200 MHz clock
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      results();
    end
  end
  task automatic results;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1)
      begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1)
      begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // program output 0, apply weight and status, judge the pin
  task automatic ov(input logic [4:0] m, input logic signed [31:0] w,
    input logic [4:0] s, input logic e);
    wr(wsio_pkg::ADDR_OUT_FUNC, {27'h0, m});
    w_set <= w;
    st_set <= s;
    repeat (12) @(posedge aclk);
    chk("dout0", {31'h0, e}, {31'h0, dout[0]});
  endtask
  // serial characters act like keys, one-cycle pulse
  task automatic serial_keys;
    logic [7:0] ch [4];
    ch = '{wsio_pkg::CH_ZERO, wsio_pkg::CH_TARE, wsio_pkg::CH_CLEAR,
      wsio_pkg::CH_PRINT};
    for (int i = 0; i < 4; i++)
    begin
      @(posedge aclk);
      rx_data <= ch[i];
      rx_valid <= 1'b1;
      @(posedge aclk);
      rx_valid <= 1'b0;
      #1 chk("keys", 32'h1 << i, {28'h0, keys});
    end
  endtask
  // input 0 tares, input 1 shows peak
  task automatic pin_keys;
    logic seen;
    seen = 1'b0;
    wr(wsio_pkg::ADDR_IN_FUNC, 32'h62);
    din <= 4'h3;
    repeat (4)
    begin
      @(posedge aclk);
      #1 seen = seen | (keys[1] === 1'b1);
    end
    chk("key_tare", 32'h1, {31'h0, seen});
    chk("peak_show", 32'h1, {31'h0, peak_show});
    @(posedge aclk);
    din <= 4'h0;
  endtask
  // setpoint entry steps through five values, then ends
  task automatic entry_walk;
    wr(wsio_pkg::ADDR_ENTRY_CTRL, 32'h1);
    for (int i = 0; i < 5; i++)
      wr(wsio_pkg::ADDR_ENTRY_DATA, 32'h10 + i);
    rd(wsio_pkg::ADDR_ENTRY_CTRL);
    chk("entry_ctrl", 32'h0, rd_data);
    rd(wsio_pkg::ADDR_SP_LAST);
    chk("sp_last", 32'h14, rd_data);
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    chk("dout", 32'h0, {27'h0, dout});
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(wsio_pkg::ADDR_SP_BASE, 32'd100);
    wr(wsio_pkg::ADDR_SP_BASE + 8'h4, 32'd200);
    wr(wsio_pkg::ADDR_ZERO_LIM, 32'd10);
    ov(wsio_pkg::OM_IND, 32'sd100, 5'h0, 1'b1);
    ov(wsio_pkg::OM_IND, 32'sd99, 5'h0, 1'b0);
    ov(wsio_pkg::OM_ABS_IND, -32'sd150, 5'h0, 1'b1);
    ov(wsio_pkg::OM_WIN_HI_IND, 32'sd200, 5'h0, 1'b1);
    ov(wsio_pkg::OM_WIN_HI_IND, 32'sd201, 5'h0, 1'b0);
    ov(wsio_pkg::OM_WIN_LO_IND, 32'sd150, 5'h0, 1'b0);
    ov(wsio_pkg::OM_ABS_NET, -32'sd50, 5'h0, 1'b1);
    ov(wsio_pkg::OM_WIN_HI_NET, 32'sd250, 5'h0, 1'b1);
    ov(wsio_pkg::OM_WIN_LO_NET, 32'sd250, 5'h0, 1'b0);
    ov(wsio_pkg::OM_GROSS, 32'sd99, 5'h0, 1'b0);
    ov(wsio_pkg::OM_NET, 32'sd200, 5'h0, 1'b1);
    ov(wsio_pkg::OM_STAGED1, 32'sd150, 5'h0, 1'b1);
    ov(wsio_pkg::OM_STAGED2, 32'sd150, 5'h0, 1'b1);
    ov(wsio_pkg::OM_STAGED2, 32'sd250, 5'h0, 1'b0);
    ov(wsio_pkg::OM_ZERO_IND, -32'sd10, 5'h0, 1'b1);
    ov(wsio_pkg::OM_ZERO_GROSS, 32'sd11, 5'h0, 1'b0);
    ov(wsio_pkg::OM_STABLE, 32'sd0, 5'h01, 1'b1);
    ov(wsio_pkg::OM_RUN, 32'sd0, 5'h00, 1'b1);
    ov(wsio_pkg::OM_RUN, 32'sd0, 5'h10, 1'b0);
    ov(wsio_pkg::OM_NET_SHOWN, 32'sd0, 5'h0d, 1'b0);
    ov(wsio_pkg::OM_NET_SHOWN, 32'sd0, 5'h02, 1'b1);
    ov(wsio_pkg::OM_ERROR, 32'sd0, 5'h04, 1'b1);
    ov(wsio_pkg::OM_REMOTE, 32'sd500, 5'h1f, 1'b0);
    wr(wsio_pkg::ADDR_REM_SET, 32'h1);
    rd(wsio_pkg::ADDR_STATUS);
    chk("status dout", 32'h1, {31'h0, rd_data[0]});
    serial_keys();
    pin_keys();
    entry_walk();
    rd(8'h38);
    chk("rresp", {30'h0, wsio_pkg::RESP_SLVERR}, {30'h0, resp});
    results();
  end
endmodule
`default_nettype wire
